// [src/scal_band_check.sv]
// Band check for a requested shift against the yearly allowance.
`timescale 1ns/10ps
`include "scal_defines.svh"
module scal_band_check
  import scal_pkg::*;
(
  input  wire logic signed [15:0] offsetNow,
  input  wire logic signed [15:0] shiftReq,
  output logic signed [15:0]      offsetNew,
  output logic                    inBand
);
  logic signed [16:0] sum;

  // Widened sum so a large request cannot wrap back into the band.
  always_comb begin
    sum       = 17'(offsetNow) + 17'(shiftReq);
    inBand    = (sum <= 17'sd360) && (sum >= -17'sd360);
    offsetNew = sum[15:0];
  end
endmodule : scal_band_check

// [src/scal_clock_limiter.sv]
// Trusted clock with bounded yearly adjustment and security log output.
// ****************************************************************
// Overview of operation
// - Operator time shifts allowed only while yearly net shift stays within six minutes.
// - Every shift attempt emits a security log entry of clock shift kind.
// - From zero point, a forward six-minute shift is accepted and applied.
// - At full forward limit, a further five-second forward shift is refused.
// - A retard equal to the earlier advance returns the clock to zero.
// - Backward six minutes accepted from zero; further five seconds back refused.
// - Accepted shift entry is stamped in the new time base.
// - Refused shift entry carries the shift limit exception flag.
// - Refused shift entry is stamped with only the offset already in force.
// - Playback entries after a shift use the shifted trusted clock.
// - Shift entries carry the applied offset amount.
// - Trusted clock and timestamps resolve to one second.
// ****************************************************************
`timescale 1ns/10ps
`include "scal_defines.svh"
module scal_clock_limiter
  import scal_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire scal_shift_req_t shiftReq,
  input  wire logic            playbackEvent,
  output scal_log_entry_t      logEntry,
  output logic [31:0]          trustedTime,
  output logic signed [15:0]   yearOffset
);
  // ****************************************************************
  // Design notes
  // ****************************************************************

  // The trusted clock is kept as two parts: a base that counts seconds and takes
  // in the offset at year end, and a signed offset that holds the net operator shift for
  // the current calendar year. Keeping them apart lets the band check work on
  // a 16-bit quantity instead of comparing two 32-bit times.

  // A request is judged against the offset in force at the edge that takes it.
  // An accepted request moves the offset at once; a refused one leaves every
  // part of the time base alone and only produces a log entry.

  // At the last second of the year the offset is folded into the base, so the
  // time seen outside does not jump, and the offset restarts at zero. This
  // re-centres the allowance without any operator action.

  // Limitations: one request is taken per cycle, a playback pulse that meets a
  // shift in the same cycle is not logged, and a shift taken in the same cycle
  // as a second tick is stamped with the time before that tick.

  // Complete state of the block; it is registered as a whole.
  typedef struct packed {
    logic [31:0]        baseTime;
    logic [31:0]        yearSec;
    logic signed [15:0] offset;
    logic [31:0]        trusted;
    scal_log_entry_t    entry;
  } scal_state_t;

  scal_state_t        state;
  scal_state_t        next_state;
  logic               tick;
  logic signed [15:0] offsetNew;
  logic               inBand;
  logic [31:0]        shiftedTime;
  logic [31:0]        candTime;
  logic               yearEnd;
  logic               shiftTake;
  logic               playTake;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  scal_second_tick u_tick (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tick    (tick)
  );

  scal_band_check u_band (
    .offsetNow (state.offset),
    .shiftReq  (shiftReq.shiftSec),
    .offsetNew (offsetNew),
    .inBand    (inBand)
  );

  // Trusted time is held in its own register, so the output comes from flops.
  assign shiftedTime = state.trusted;
  // Stamp for an accepted shift: the present base plus the offset it would make.
  assign candTime    = state.baseTime + 32'(offsetNew);

  // ****************************************************************
  // Request decode
  // ****************************************************************

  // Last second of the calendar year; the band re-centres on this tick.
  assign yearEnd   = tick && (state.yearSec == 32'(`SCAL_YEAR_SEC - 1));

  // A shift is always taken; a playback pulse only when no shift shares the cycle.
  // The pulse is dropped rather than queued, which keeps the block free of buffers.
  assign shiftTake = shiftReq.valid;
  assign playTake  = playbackEvent && !shiftReq.valid;

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Shift requests take priority over playback events in the same cycle;
  // the playback record is dropped in that case, a known limitation.
  always_comb begin
    next_state = state;
    next_state.entry = '0;
    if (tick) begin
      next_state.baseTime = state.baseTime + 32'h00000001;
      if (yearEnd) begin
        next_state.yearSec = 32'h00000000;
        // Fold the shift into the base so time is kept but the band re-centres.
        next_state.baseTime = state.baseTime + 32'h00000001 + 32'(state.offset);
        next_state.offset   = 16'(`SCAL_OFFSET_RESET);
      end else begin
        next_state.yearSec = state.yearSec + 32'h00000001;
      end
    end
    if (shiftTake) begin
      next_state.entry.valid = 1'b1;
      next_state.entry.kind  = SCAL_REC_SHIFT;
      if (inBand) begin
        if (yearEnd) begin
          // The shift belongs to the closing year, so fold it into the base
          // with the rest; it is then neither lost nor charged to the new year.
          next_state.baseTime = state.baseTime + 32'h00000001 + 32'(offsetNew);
        end else begin
          next_state.offset = offsetNew;
        end
        next_state.entry.timeStamp    = candTime;
        next_state.entry.appliedShift = shiftReq.shiftSec;
      end else begin
        next_state.entry.limitException = 1'b1;
        next_state.entry.timeStamp      = shiftedTime;
        next_state.entry.appliedShift   = 16'h0000;
      end
    end else if (playTake) begin
      next_state.entry.valid     = 1'b1;
      next_state.entry.kind      = SCAL_REC_PLAYBACK;
      next_state.entry.timeStamp = shiftedTime;
    end
    // Trusted time follows whatever base and offset this cycle settles on;
    // registering the sum keeps an adder out of the output path.
    next_state.trusted = next_state.baseTime + 32'(next_state.offset);
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Whole state in one register; reset clears time, offset and the log pulse.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs are taken straight from the state register.
  // The trusted time is registered as well, so no adder sits before a pin.
  assign logEntry    = state.entry;
  assign trustedTime = shiftedTime;
  assign yearOffset  = state.offset;

  // ****************************************************************
  // Checks
  // ****************************************************************

  // Request handling: every shift request is logged, and the offset moves only when
  // the request is accepted; the stamp follows the time base in force.
  band_held_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state.offset <= 16'sd360) && (state.offset >= -16'sd360))
    else $error("Offset left the band.");

  every_log_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    shiftReq.valid |=> (logEntry.valid && logEntry.kind == SCAL_REC_SHIFT))
    else $error("Shift attempt not logged.");

  accept_apply_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && inBand && !tick) |=> (yearOffset == $past(offsetNew)))
    else $error("Accepted shift not applied.");

  refuse_keep_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && !inBand && !tick) |=> $stable(yearOffset))
    else $error("Refused shift changed offset.");

  refuse_flag_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    shiftReq.valid |=> (logEntry.limitException == !$past(inBand)))
    else $error("Exception flag wrong.");

  refuse_stamp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && !inBand) |=> (logEntry.timeStamp == $past(trustedTime)))
    else $error("Refused stamp wrong.");

  new_base_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && inBand) |=> (logEntry.timeStamp == $past(candTime)))
    else $error("Accepted stamp wrong.");

  play_stamp_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (playbackEvent && !shiftReq.valid) |=> (logEntry.timeStamp == $past(trustedTime)))
    else $error("Playback stamp wrong.");

  // Playback on its own gives exactly one playback record, free of shift fields.
  play_kind_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (playbackEvent && !shiftReq.valid) |=>
      (logEntry.valid && logEntry.kind == SCAL_REC_PLAYBACK))
    else $error("Playback not logged.");

  play_no_shift_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (playbackEvent && !shiftReq.valid) |=> (logEntry.appliedShift == 16'sh0000))
    else $error("Playback record carries a shift.");

  play_no_exc_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (playbackEvent && !shiftReq.valid) |=> !logEntry.limitException)
    else $error("Playback record flagged as refused.");

  // The log output is a one-cycle pulse; no request means no entry.
  log_pulse_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!shiftReq.valid && !playbackEvent) |=> !logEntry.valid)
    else $error("Log entry without a request.");

  // An accepted shift records the amount requested; a refused one records none.
  applied_amount_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && inBand) |=> (logEntry.appliedShift == $past(shiftReq.shiftSec)))
    else $error("Applied amount not logged.");

  refused_amount_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && !inBand) |=> (logEntry.appliedShift == 16'sh0000))
    else $error("Refused amount logged.");

  // ****************************************************************
  // Band edge checks
  // ****************************************************************

  // These pin the band to its inclusive limits of six minutes either way,
  // independent of how the adder in the band check is written.
  fwd_edge_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && state.offset == 16'sh0000 && shiftReq.shiftSec == 16'sh0168)
      |-> inBand)
    else $error("Six minutes forward refused.");

  fwd_over_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && state.offset == 16'sh0168 && shiftReq.shiftSec == 16'sh0005)
      |-> !inBand)
    else $error("Forward shift past the limit accepted.");

  back_edge_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && state.offset == 16'sh0000 && shiftReq.shiftSec == -16'sh0168)
      |-> inBand)
    else $error("Six minutes back refused.");

  back_over_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && state.offset == -16'sh0168 && shiftReq.shiftSec == -16'sh0005)
      |-> !inBand)
    else $error("Backward shift past the limit accepted.");

  // Undoing the whole shift in force brings the offset back to the zero point.
  return_zero_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && !tick && shiftReq.shiftSec == -state.offset)
      |=> (yearOffset == 16'sh0000))
    else $error("Return to zero point failed.");

  // ****************************************************************
  // Time base checks
  // ****************************************************************

  // Time moves only on a second tick or a shift; anything else would let the
  // stamps drift away from the trusted clock.
  time_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!tick && !shiftReq.valid) |=> $stable(trustedTime))
    else $error("Trusted time moved without cause.");

  offset_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!tick && !shiftReq.valid) |=> $stable(yearOffset))
    else $error("Offset moved without a request.");

  // An accepted shift moves the time by exactly the requested amount.
  accept_time_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && inBand && !tick) |=>
      (trustedTime == $past(trustedTime) + 32'($past(shiftReq.shiftSec))))
    else $error("Trusted time not moved by the shift.");

  // A refused amount is never applied to the time.
  refuse_time_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (shiftReq.valid && !inBand && !tick) |=> $stable(trustedTime))
    else $error("Refused shift moved the time.");

  // The year counter never reaches the year length, so the rollover second is
  // always seen and the allowance is re-centred once a year.
  year_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state.yearSec < 32'(`SCAL_YEAR_SEC)))
    else $error("Year counter overran.");
endmodule : scal_clock_limiter

// [src/scal_defines.svh]
// Constants for the secure clock adjust limiter.
`ifndef SCAL_DEFINES_SVH
`define SCAL_DEFINES_SVH
`define SCAL_LIMIT_MIN      6
`define SCAL_LIMIT_SEC      (`SCAL_LIMIT_MIN * 60)
`define SCAL_SYS_CLK_HZ     10000000
`define SCAL_TICK_CYCLES    (`SCAL_SYS_CLK_HZ / 1)
`define SCAL_YEAR_SEC       31536000
`define SCAL_TIME_RESET     32'h00000000
`define SCAL_OFFSET_RESET   16'h0000
`endif

// [src/scal_pkg.sv]
// Types shared by the secure clock adjust limiter files.
package scal_pkg;
  typedef enum logic [1:0] {
    SCAL_REC_NONE,
    SCAL_REC_SHIFT,
    SCAL_REC_PLAYBACK
  } scal_rec_kind_t;

  typedef struct packed {
    logic        valid;
    logic signed [15:0] shiftSec;
  } scal_shift_req_t;

  typedef struct packed {
    logic               valid;
    scal_rec_kind_t     kind;
    logic [31:0]        timeStamp;
    logic signed [15:0] appliedShift;
    logic               limitException;
  } scal_log_entry_t;
endpackage : scal_pkg

// [src/scal_second_tick.sv]
// One-second tick generator.
`timescale 1ns/10ps
`include "scal_defines.svh"
module scal_second_tick
  import scal_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic arst_n,
  output logic      tick
);
  typedef struct packed {
    logic [23:0] count;
    logic        tick;
  } scal_tick_state_t;

  scal_tick_state_t state;
  scal_tick_state_t next_state;

  // Divider counts the full period and pulses once per second.
  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 24'(`SCAL_TICK_CYCLES - 1)) begin
      next_state.count = 24'h000000;
      next_state.tick  = 1'b1;
    end else begin
      next_state.count = state.count + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick = state.tick;
endmodule : scal_second_tick

// [verification/scal_exhibitor_model.sv]
// Exhibitor-side model that issues time shift and playback requests.
`timescale 1ns/10ps
module scal_exhibitor_model
  import scal_pkg::*;
(
  input  wire logic sys_clk,
  output scal_shift_req_t shiftReq,
  output logic            playbackEvent
);
  // Requests start idle so nothing is taken while reset is released.
  initial begin
    shiftReq = '0;
    playbackEvent = 1'b0;
  end

  // One-cycle request pulse; afterwards the amount is inverted, not held.
  task automatic sendShift(input logic signed [15:0] sec);
    @(posedge sys_clk);
    shiftReq <= '{valid: 1'b1, shiftSec: sec};
    @(posedge sys_clk);
    shiftReq <= '{valid: 1'b0, shiftSec: ~sec};
  endtask : sendShift

  // One-cycle playback pulse.
  task automatic sendPlay();
    @(posedge sys_clk);
    playbackEvent <= 1'b1;
    @(posedge sys_clk);
    playbackEvent <= 1'b0;
  endtask : sendPlay

  // Shift and playback in one cycle; the block is expected to log the shift only.
  task automatic sendBoth(input logic signed [15:0] sec);
    @(posedge sys_clk);
    shiftReq      <= '{valid: 1'b1, shiftSec: sec};
    playbackEvent <= 1'b1;
    @(posedge sys_clk);
    shiftReq      <= '{valid: 1'b0, shiftSec: ~sec};
    playbackEvent <= 1'b0;
  endtask : sendBoth
endmodule : scal_exhibitor_model

// [verification/testbench.sv]
// Self-checking bench for the secure clock adjust limiter.
`timescale 1ns/10ps
module testbench
  import scal_pkg::*;
;
  logic                sys_clk = 1'b0;
  logic                arst_n = 1'b0;
  scal_shift_req_t     shiftReq;
  logic                playbackEvent;
  scal_log_entry_t     logEntry;
  logic [31:0]         trustedTime;
  logic signed [15:0]  yearOffset;
  int                  errTotal = 0;
  int                  testsRun = 0;
  int                  cycles = 0;

  always #50 sys_clk = ~sys_clk;

  scal_exhibitor_model u_host (.sys_clk(sys_clk), .shiftReq(shiftReq),
                               .playbackEvent(playbackEvent));
  scal_clock_limiter u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .shiftReq(shiftReq),
                            .playbackEvent(playbackEvent), .logEntry(logEntry),
                            .trustedTime(trustedTime), .yearOffset(yearOffset));

  // ****************************************************************
  // Shared checks
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The second tick is far beyond the run, so stamps equal the offset alone.
  task automatic expectShift(input logic signed [15:0] sec, input logic refused,
                             input logic signed [15:0] expOff);
    u_host.sendShift(sec);
    @(negedge sys_clk);
    check("logValid", logEntry.valid, 1'b1);
    check("logKind", logEntry.kind, SCAL_REC_SHIFT);
    check("logStamp", logEntry.timeStamp, 32'(expOff));
    check("logApplied", logEntry.appliedShift, refused ? 16'sh0000 : sec);
    check("logRefused", logEntry.limitException, refused);
    check("yearOffset", yearOffset, expOff);
    check("trustedTime", trustedTime, 32'(expOff));
    @(negedge sys_clk);
    check("logPulse", logEntry.valid, 1'b0);
  endtask : expectShift

  task automatic expectPlay(input logic signed [15:0] expOff);
    u_host.sendPlay();
    @(negedge sys_clk);
    check("playValid", logEntry.valid, 1'b1);
    check("playKind", logEntry.kind, SCAL_REC_PLAYBACK);
    check("playStamp", logEntry.timeStamp, 32'(expOff));
  endtask : expectPlay

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic testForwardLimit();
    expectShift(16'sh0168, 1'b0, 16'sh0168);
    expectPlay(16'sh0168);
    expectShift(16'sh0005, 1'b1, 16'sh0168);
    expectShift(16'sh7fff, 1'b1, 16'sh0168);
  endtask : testForwardLimit

  task automatic testReturnZero();
    expectShift(-16'sh0168, 1'b0, 16'sh0000);
  endtask : testReturnZero

  task automatic testBackwardLimit();
    expectShift(-16'sh0168, 1'b0, -16'sh0168);
    expectPlay(-16'sh0168);
    expectShift(-16'sh0005, 1'b1, -16'sh0168);
    expectShift(16'sh8000, 1'b1, -16'sh0168);
  endtask : testBackwardLimit

  // Reset in mid-run clears the offset, the time base and the log pulse.
  task automatic testMidReset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    @(negedge sys_clk);
    check("midOffset", yearOffset, 16'sh0000);
    check("midTime", trustedTime, 32'h00000000);
    check("midLog", logEntry.valid, 1'b0);
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    expectShift(16'sh0168, 1'b0, 16'sh0168);
  endtask : testMidReset

  // A playback pulse that meets a shift in the same cycle is not logged.
  task automatic testShiftWithPlay();
    u_host.sendBoth(-16'sh0168);
    @(negedge sys_clk);
    check("bothKind", logEntry.kind, SCAL_REC_SHIFT);
    check("bothStamp", logEntry.timeStamp, 32'h00000000);
    check("bothOffset", yearOffset, 16'sh0000);
    @(negedge sys_clk);
    check("bothDrop", logEntry.valid, 1'b0);
  endtask : testShiftWithPlay

  // Prints the counts and the verdict, then ends the run.
  task automatic printVerdict();
    $display("Checks run %0d, mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : printVerdict

  // Ceiling well above the fifty or so cycles the scenarios need.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      printVerdict();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    check("resetOffset", yearOffset, 16'sh0000);
    check("resetTime", trustedTime, 32'h00000000);
    check("resetLog", logEntry.valid, 1'b0);
    testForwardLimit();
    testReturnZero();
    testBackwardLimit();
    testMidReset();
    testShiftWithPlay();
    printVerdict();
  end
endmodule : testbench
